// *** rasp_pkg.sv ***
// constants and types for the remote axis status and i/o port block
package rasp_pkg;
   localparam int unsigned STS_W = 16;
   localparam int unsigned PIN_W = 8;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BUF_DEPTH = 64;
   localparam int unsigned PTR_W = 6;
   // status word bit positions
   localparam int unsigned ST_SUM = 0;
   localparam int unsigned ST_STOP = 1;
   localparam int unsigned ST_ERR = 2;
   localparam int unsigned ST_EVT = 3;
   localparam int unsigned ST_SIM_LO = 4;
   localparam int unsigned ST_SIM_HI = 5;
   localparam int unsigned ST_PRF = 6;
   localparam int unsigned ST_CMP3 = 7;
   localparam int unsigned ST_BUSY = 8;
   localparam int unsigned ST_SYNC_LO = 9;
   localparam int unsigned ST_GRP_LO = 12;
   localparam int unsigned GRP_W = 3;
   localparam int unsigned SYNC_W = 7;
   localparam int unsigned SERIAL_PIN_LO = 4;
   // command code, omitted-data value and group-from-pins setting
   localparam logic [15:0] CMD_STOP_IRQ_RST = 16'h0008;
   localparam logic [15:0] DATA_OMITTED = 16'h0000;
   localparam logic [2:0] GRP_FROM_PINS = 3'h0;
   // reset values
   localparam logic [7:0] PIN_OUT_RST = 8'h00;
   localparam logic [15:0] STS_RST = 16'h0000;
   typedef enum logic [1:0] {
      RASP_PS_CMD = 2'b00,
      RASP_PS_LO = 2'b01,
      RASP_PS_HI = 2'b10
   } rasp_parse_type;
endpackage

// *** rasp_cmd_parser.sv ***
// command framing: splits received words into command plus two data words
`timescale 1ns/1ps
`default_nettype none
module rasp_cmd_parser
#(
   parameter int unsigned WORD_W = 16
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic word_valid,
   input wire logic [WORD_W-1:0] word_data,
   input wire logic frame_end,
   input wire logic cmd_has_data,
   output logic cmd_valid,
   output logic [WORD_W-1:0] cmd_code,
   output logic [WORD_W-1:0] cmd_lo,
   output logic [WORD_W-1:0] cmd_hi
);
   rasp_pkg::rasp_parse_type st_r;
   rasp_pkg::rasp_parse_type st_nxt;
   logic [WORD_W-1:0] code_r;
   logic [WORD_W-1:0] lo_r;
   wire take = clk_en && word_valid;
   wire close = clk_en && frame_end && !word_valid && (st_r != rasp_pkg::RASP_PS_CMD);

   // next parse state
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         rasp_pkg::RASP_PS_CMD: if (take && cmd_has_data) st_nxt = rasp_pkg::RASP_PS_LO;
         rasp_pkg::RASP_PS_LO: if (take) st_nxt = rasp_pkg::RASP_PS_HI;
         rasp_pkg::RASP_PS_HI: if (take) st_nxt = rasp_pkg::RASP_PS_CMD;
         default: st_nxt = rasp_pkg::RASP_PS_CMD;
      endcase
      if (close)
         st_nxt = rasp_pkg::RASP_PS_CMD;
   end

   // word capture and command issue
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= rasp_pkg::RASP_PS_CMD;
         code_r <= '0;
         lo_r <= '0;
         cmd_valid <= 1'b0;
         cmd_code <= '0;
         cmd_lo <= '0;
         cmd_hi <= '0;
      end
      else if (clk_en)
      begin
         st_r <= st_nxt;
         cmd_valid <= 1'b0;
         if (take && st_r == rasp_pkg::RASP_PS_CMD)
         begin
            code_r <= word_data;
            lo_r <= rasp_pkg::DATA_OMITTED;
            if (!cmd_has_data)
            begin
               cmd_valid <= 1'b1;
               cmd_code <= word_data;
               cmd_lo <= rasp_pkg::DATA_OMITTED;
               cmd_hi <= rasp_pkg::DATA_OMITTED;
            end
         end
         else if (take && st_r == rasp_pkg::RASP_PS_LO)
            lo_r <= word_data;
         else if (take && st_r == rasp_pkg::RASP_PS_HI)
         begin
            cmd_valid <= 1'b1;
            cmd_code <= code_r;
            cmd_lo <= lo_r;
            cmd_hi <= word_data;
         end
         else if (close)
         begin
            cmd_valid <= 1'b1;
            cmd_code <= code_r;
            cmd_lo <= lo_r;
            cmd_hi <= rasp_pkg::DATA_OMITTED;
         end
      end
   end
endmodule
`default_nettype wire

// *** rasp_status_io.sv ***
// remote axis status word, general-purpose i/o ports and command framing
// Function
// - summary flag set when stop, error, event set
// - stop flag set on stop, cleared by 0008h
// - error flag cleared by error cause access
// - event flag cleared by event cause access
// - bits 5,4 simultaneous-stop info, reader ignores
// - bit 6 shows operation pre-register full
// - bit 7 shows comparator 3 pre-register full
// - bit 8 mirrors busy, pulse start to stop
// - group bits from pins or nonzero setting
// - sync layout: bits 15-9 sync data, ignored
// - irq disable holds summary flag at zero
// - input byte returns pin levels 7-0
// - serial mode zeroes input bits 7-4
// - output pins read back driven state
// - monitor disable zeroes output-pin input bits
// - output byte sets driven pin levels
// - serial mode ignores output bits 7-4
// - omitted data words taken as 0000h
// - ports 3..0: out, in, status hi, lo
// - direction bits select pin in or out
`timescale 1ns/1ps
`default_nettype none
module rasp_status_io
#(
   parameter int unsigned PIN_W = 8,
   parameter int unsigned WORD_W = 16
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // received words from the serial link
   input wire logic rx_word_valid,
   input wire logic [WORD_W-1:0] rx_word,
   input wire logic rx_frame_end,
   input wire logic cmd_has_data,
   // motion engine events and levels
   input wire logic op_stop_evt,
   input wire logic err_irq_evt,
   input wire logic evt_irq_evt,
   input wire logic pulse_start_evt,
   input wire logic op_prereg_full,
   input wire logic cmp3_prereg_full,
   input wire logic [1:0] sim_stop_info,
   input wire logic [6:0] clock_sync_field,
   input wire logic error_cause_access,
   input wire logic event_cause_access,
   // configuration
   input wire logic sync_layout_select,
   input wire logic sync_enable_select,
   input wire logic [2:0] group_number_setting,
   input wire logic [2:0] group_input_pins,
   input wire logic irq_disable_bit,
   input wire logic input_monitor_disable,
   input wire logic serial_bus_pin_mode,
   input wire logic [PIN_W-1:0] pin_direction_bits,
   // cyclic port writes
   input wire logic port3_wr,
   input wire logic [PIN_W-1:0] port3_wdata,
   // general-purpose pins
   input wire logic [PIN_W-1:0] pin_in_bits,
   output logic [PIN_W-1:0] pin_out_bits,
   output logic [PIN_W-1:0] pin_out_en,
   // cyclic ports and status
   output logic [7:0] port3_rd,
   output logic [7:0] port2_rd,
   output logic [7:0] port1_rd,
   output logic [7:0] port0_rd,
   output logic [WORD_W-1:0] main_status_word,
   output logic busy_output_signal,
   output logic irq_summary_flag,
   // decoded commands for the motion engine
   output logic cmd_valid,
   output logic [WORD_W-1:0] cmd_code,
   output logic [WORD_W-1:0] cmd_lo,
   output logic [WORD_W-1:0] cmd_hi
);
   logic stop_flag_r;
   logic error_irq_flag_r;
   logic event_irq_flag_r;
   logic pulse_busy_flag_r;
   logic [PIN_W-1:0] pin_output_levels_r;
   logic [PIN_W-1:0] pin_input_levels;
   logic [PIN_W-1:0] drive_nxt;
   logic [PIN_W-1:0] oe_nxt;
   logic [PIN_W-1:0] serial_mask;
   logic [WORD_W-1:0] sts_nxt;
   logic [2:0] group_number_field;
   logic sum_nxt;
   logic stop_clr;
   logic p_valid;
   logic [WORD_W-1:0] p_code;
   logic [WORD_W-1:0] p_lo;
   logic [WORD_W-1:0] p_hi;

   // command framing
   rasp_cmd_parser #(.WORD_W(WORD_W)) u_parser
   (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .word_valid(rx_word_valid),
      .word_data(rx_word),
      .frame_end(rx_frame_end),
      .cmd_has_data(cmd_has_data),
      .cmd_valid(p_valid),
      .cmd_code(p_code),
      .cmd_lo(p_lo),
      .cmd_hi(p_hi)
   );

   // pins 7-4 belong to the serial bus in serial mode
   assign serial_mask = serial_bus_pin_mode ?
      {{(PIN_W-rasp_pkg::SERIAL_PIN_LO){1'b0}}, {rasp_pkg::SERIAL_PIN_LO{1'b1}}} : '1;
   assign oe_nxt = pin_direction_bits & serial_mask;
   assign drive_nxt = pin_output_levels_r & oe_nxt;

   // input byte: pin level, or driven state on outputs
   assign pin_input_levels = ((pin_in_bits & ~pin_direction_bits)
      | (pin_out_bits & pin_direction_bits & {PIN_W{!input_monitor_disable}}))
      & serial_mask;

   assign stop_clr = p_valid && p_code == rasp_pkg::CMD_STOP_IRQ_RST;
   assign sum_nxt = !irq_disable_bit
      && (stop_flag_r || error_irq_flag_r || event_irq_flag_r);
   assign group_number_field = (group_number_setting == rasp_pkg::GRP_FROM_PINS) ?
      group_input_pins : group_number_setting;

   // status word assembly
   always_comb
   begin
      sts_nxt = rasp_pkg::STS_RST;
      sts_nxt[rasp_pkg::ST_SUM] = sum_nxt;
      sts_nxt[rasp_pkg::ST_STOP] = stop_flag_r;
      sts_nxt[rasp_pkg::ST_ERR] = error_irq_flag_r;
      sts_nxt[rasp_pkg::ST_EVT] = event_irq_flag_r;
      sts_nxt[rasp_pkg::ST_PRF] = op_prereg_full;
      sts_nxt[rasp_pkg::ST_CMP3] = cmp3_prereg_full;
      sts_nxt[rasp_pkg::ST_BUSY] = pulse_busy_flag_r;
      if (sync_enable_select)
         sts_nxt[rasp_pkg::ST_SIM_HI:rasp_pkg::ST_SIM_LO] = sim_stop_info;
      if (sync_layout_select || sync_enable_select)
         sts_nxt[15:rasp_pkg::ST_SYNC_LO] = clock_sync_field;
      else
         sts_nxt[14:rasp_pkg::ST_GRP_LO] = group_number_field;
   end

   // interrupt flags, busy; set wins over clear
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stop_flag_r <= 1'b0;
         error_irq_flag_r <= 1'b0;
         event_irq_flag_r <= 1'b0;
         pulse_busy_flag_r <= 1'b0;
      end
      else if (clk_en)
      begin
         stop_flag_r <= op_stop_evt || (stop_flag_r && !stop_clr);
         error_irq_flag_r <= err_irq_evt || (error_irq_flag_r && !error_cause_access);
         event_irq_flag_r <= evt_irq_evt || (event_irq_flag_r && !event_cause_access);
         pulse_busy_flag_r <= pulse_start_evt || (pulse_busy_flag_r && !op_stop_evt);
      end
   end

   // output register and pin drivers
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_output_levels_r <= rasp_pkg::PIN_OUT_RST;
         pin_out_bits <= rasp_pkg::PIN_OUT_RST;
         pin_out_en <= '0;
      end
      else if (clk_en)
      begin
         if (port3_wr)
            pin_output_levels_r <= port3_wdata;
         pin_out_bits <= drive_nxt;
         pin_out_en <= oe_nxt;
      end
   end

   // registered port images and command outputs
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         port3_rd <= '0;
         port2_rd <= '0;
         port1_rd <= '0;
         port0_rd <= '0;
         main_status_word <= rasp_pkg::STS_RST;
         busy_output_signal <= 1'b0;
         irq_summary_flag <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_code <= '0;
         cmd_lo <= '0;
         cmd_hi <= '0;
      end
      else if (clk_en)
      begin
         port3_rd <= pin_output_levels_r;
         port2_rd <= pin_input_levels;
         port1_rd <= sts_nxt[15:8];
         port0_rd <= sts_nxt[7:0];
         main_status_word <= sts_nxt;
         busy_output_signal <= pulse_busy_flag_r;
         irq_summary_flag <= sum_nxt;
         cmd_valid <= p_valid;
         cmd_code <= p_code;
         cmd_lo <= p_lo;
         cmd_hi <= p_hi;
      end
   end
endmodule
`default_nettype wire

// *** rasp_ctrl_model.sv ***
// model of the controller that sends command frames to the block
`timescale 1ns/1ps
`default_nettype none
module rasp_ctrl_model
(
   input wire logic core_clk,
   output logic rx_word_valid,
   output logic [15:0] rx_word,
   output logic rx_frame_end,
   output logic cmd_has_data
);
   int n_words = 0;
   initial
   begin
      rx_word_valid = 0;
      rx_word = 16'hffff;
      rx_frame_end = 0;
   end
   // write-register codes carry two data words, all others none
   assign cmd_has_data = rx_word[15:4] == 12'h00b;
   // one word per cycle, never more than the buffer holds
   task send_word(input logic [15:0] w);
      @(posedge core_clk);
      #1;
      rx_word_valid = n_words < 64;
      rx_word = w;
      n_words++;
   endtask
   // released word lines show the inverse of the last word
   task end_frame;
      @(posedge core_clk);
      #1;
      rx_word_valid = 0;
      rx_word = ~rx_word;
      rx_frame_end = 1;
      n_words = 0;
      @(posedge core_clk);
      #1;
      rx_frame_end = 0;
   endtask
endmodule
`default_nettype wire

// *** rasp_status_io_chk.sv ***
// assertions on the status word, pin ports and command outputs
`timescale 1ns/1ps
`default_nettype none
module rasp_status_io_chk
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic op_stop_evt,
   input wire logic err_irq_evt,
   input wire logic pulse_start_evt,
   input wire logic sync_layout_select,
   input wire logic sync_enable_select,
   input wire logic [2:0] group_number_setting,
   input wire logic serial_bus_pin_mode,
   input wire logic [7:0] pin_out_bits,
   input wire logic [7:0] port1_rd,
   input wire logic [7:0] port0_rd,
   input wire logic [15:0] main_status_word,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_code,
   input wire logic [15:0] cmd_lo,
   input wire logic [15:0] cmd_hi
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_sum_cause: assert property (main_status_word[0] |-> |main_status_word[3:1])
      else $error("summary without cause");
   a_stop_set: assert property (clk_en && op_stop_evt ##1 clk_en |-> ##1 main_status_word[1])
      else $error("stop flag missing");
   a_err_set: assert property (clk_en && err_irq_evt ##1 clk_en |-> ##1 main_status_word[2])
      else $error("error flag missing");
   a_busy_stop: assert property (clk_en && op_stop_evt && !pulse_start_evt ##1 clk_en
      |-> ##1 !main_status_word[8])
      else $error("busy after stop");
   a_port_map: assert property ({port1_rd, port0_rd} == main_status_word)
      else $error("status ports differ");
   a_cmd_hold: assert property (!cmd_valid |-> $stable({cmd_code, cmd_lo, cmd_hi}))
      else $error("command fields moved");
   a_group_set: assert property ($past(arst_n) && $past(clk_en) && $past(group_number_setting)
      != 3'h0 && $past(!sync_layout_select && !sync_enable_select)
      |-> main_status_word[14:12] == $past(group_number_setting))
      else $error("group field wrong");
   a_serial_out: assert property ($past(arst_n) && $past(clk_en) && $past(serial_bus_pin_mode)
      |-> pin_out_bits[7:4] == 4'h0)
      else $error("serial pins driven");
   a_sim_zero: assert property ($past(arst_n) && $past(clk_en && !sync_enable_select)
      |-> main_status_word[5:4] == 2'h0)
      else $error("stop info shown");
endmodule
`default_nettype wire

// *** rasp_status_io_bench.sv ***
// self-checking bench for the status and i/o port block
`timescale 1ns/1ps
`default_nettype none
bind rasp_status_io rasp_status_io_chk i_chk (.core_clk, .arst_n, .clk_en, .op_stop_evt,
   .err_irq_evt, .pulse_start_evt, .sync_layout_select, .sync_enable_select,
   .group_number_setting, .serial_bus_pin_mode, .pin_out_bits, .port1_rd, .port0_rd,
   .main_status_word, .cmd_valid, .cmd_code, .cmd_lo, .cmd_hi);
module rasp_status_io_bench;
   logic core_clk = 0, arst_n = 0, clk_en = 1, rx_word_valid, rx_frame_end, cmd_has_data;
   logic busy_output_signal, irq_summary_flag, cmd_valid, port3_wr = 0;
   logic [15:0] rx_word, main_status_word, cmd_code, cmd_lo, cmd_hi;
   logic op_stop_evt = 0, err_irq_evt = 0, evt_irq_evt = 0, pulse_start_evt = 0;
   logic op_prereg_full = 0, cmp3_prereg_full = 0, error_cause_access = 0;
   logic event_cause_access = 0, sync_layout_select = 0, sync_enable_select = 0;
   logic irq_disable_bit = 0, input_monitor_disable = 0, serial_bus_pin_mode = 0;
   logic [1:0] sim_stop_info = 2'h3;
   logic [6:0] clock_sync_field = 7'h55;
   logic [2:0] group_number_setting = 3'h0, group_input_pins = 3'h5;
   logic [7:0] pin_direction_bits = 8'h0f, port3_wdata = 8'ha5, pin_in_bits = 8'h30;
   logic [7:0] pin_out_bits, pin_out_en, port3_rd, port2_rd, port1_rd, port0_rd;
   int failures = 0, n_checks = 0;
   // 250 MHz clock
   always #2 core_clk = ~core_clk;
   rasp_ctrl_model i_ctrl (.core_clk, .rx_word_valid, .rx_word, .rx_frame_end, .cmd_has_data);
   rasp_status_io i_dut (.core_clk, .arst_n, .clk_en, .rx_word_valid, .rx_word, .rx_frame_end,
      .cmd_has_data, .op_stop_evt, .err_irq_evt, .evt_irq_evt, .pulse_start_evt,
      .op_prereg_full, .cmp3_prereg_full, .sim_stop_info, .clock_sync_field,
      .error_cause_access, .event_cause_access, .sync_layout_select, .sync_enable_select,
      .group_number_setting, .group_input_pins, .irq_disable_bit, .input_monitor_disable,
      .serial_bus_pin_mode, .pin_direction_bits, .port3_wr, .port3_wdata, .pin_in_bits,
      .pin_out_bits, .pin_out_en, .port3_rd, .port2_rd, .port1_rd, .port0_rd,
      .main_status_word, .busy_output_signal, .irq_summary_flag, .cmd_valid, .cmd_code,
      .cmd_lo, .cmd_hi);
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s got %h", $time, m, got);
      end
   endtask
   // one-cycle pulse, then wait for the status image
   task automatic pulse(ref logic s);
      s = 1;
      step(1);
      s = 0;
      step(1);
   endtask
   task automatic cmd_chk(input logic [15:0] c, input logic [15:0] lo, input logic [15:0] hi);
      int k;
      k = 0;
      while (cmd_valid !== 1'b1 && k < 8)
      begin
         step(1);
         k++;
      end
      chk({cmd_valid, cmd_code, cmd_lo, cmd_hi} === {1'b1, c, lo, hi}, 1, "command");
   endtask
   task report_and_stop;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #20000;
      failures++;
      $display("unexpected at %0t: hang", $time);
      report_and_stop;
   end
   // test sequence
   initial
   begin
      step(6);
      arst_n = 1;
      step(2);
      chk(main_status_word & 16'h0fff, 0, "reset");
      chk(main_status_word[14:12], 5, "group pins");
      pulse(op_stop_evt);
      chk({main_status_word[1:0], irq_summary_flag}, 7, "stop");
      i_ctrl.send_word(16'h0008);
      i_ctrl.end_frame;
      step(3);
      chk(main_status_word[1:0], 0, "stop clear");
      irq_disable_bit = 1;
      pulse(err_irq_evt);
      chk(main_status_word[3:0], 4, "masked");
      pulse(error_cause_access);
      irq_disable_bit = 0;
      pulse(evt_irq_evt);
      chk(main_status_word[3:0], 9, "event");
      pulse(event_cause_access);
      pulse(pulse_start_evt);
      chk({main_status_word[3:0], main_status_word[8], busy_output_signal}, 3, "busy");
      op_prereg_full = 1;
      cmp3_prereg_full = 1;
      group_number_setting = 3'h3;
      step(2);
      chk({main_status_word[14:12], main_status_word[7:6]}, 5'h0f, "full grp");
      $display("status test done");
      pulse(port3_wr);
      step(3);
      chk({pin_out_bits, pin_out_en}, 16'h050f, "pins out");
      chk({port3_rd, port2_rd}, 16'ha535, "ports");
      input_monitor_disable = 1;
      step(3);
      chk(port2_rd, 8'h30, "monitor off");
      input_monitor_disable = 0;
      pin_direction_bits = 8'hff;
      serial_bus_pin_mode = 1;
      step(3);
      chk({pin_out_bits, port2_rd}, 16'h0505, "serial");
      $display("pin test done");
      i_ctrl.send_word(16'h00b0);
      i_ctrl.send_word(16'h4567);
      i_ctrl.send_word(16'h0123);
      i_ctrl.end_frame;
      cmd_chk(16'h00b0, 16'h4567, 16'h0123);
      i_ctrl.send_word(16'h00b1);
      i_ctrl.send_word(16'h4567);
      i_ctrl.end_frame;
      cmd_chk(16'h00b1, 16'h4567, 16'h0000);
      i_ctrl.send_word(16'h00b2);
      i_ctrl.end_frame;
      cmd_chk(16'h00b2, 16'h0000, 16'h0000);
      $display("command test done");
      // group from pins, both sync layouts, clock enable freeze, reset mid-run
      group_number_setting = 3'h0;
      group_input_pins = 3'h2;
      step(2);
      chk(main_status_word[14:12], 2, "group pins again");
      sync_enable_select = 1;
      step(2);
      chk({port1_rd, port0_rd}, 16'habf0, "sync enable");
      sync_enable_select = 0;
      sync_layout_select = 1;
      step(2);
      chk({port1_rd, port0_rd}, 16'habc0, "sync layout");
      sync_layout_select = 0;
      step(2);
      clk_en = 0;
      pulse(op_stop_evt);
      chk(main_status_word, 16'h21c0, "frozen");
      clk_en = 1;
      pulse(op_stop_evt);
      chk(main_status_word, 16'h20c3, "stop ends busy");
      chk(busy_output_signal, 0, "busy off");
      arst_n = 0;
      step(2);
      arst_n = 1;
      step(2);
      chk({main_status_word[8], main_status_word[3:0], irq_summary_flag}, 0, "reset again");
      $display("mode test done");
      report_and_stop;
   end
endmodule
`default_nettype wire
